// ===== logic/sch_cfg.svh
// constants of the serial channel: register map, field layout, reset values, timing
// assumes a 100 MHz pclk and an APB master with 32-bit data
//
// Operation
// - reset gives 9600 baud, character handshake, 8 data bits, no parity, 2 stops
// - character length selectable as 7 or 8 data bits
// - with 8 bits the top data bit is sent as 0 and read as 0
// - parity is even, odd or none, chosen by the parity operand
// - one or two stop bits, chosen by the stop operand
// - one configuration write carries mode, baud, length, parity and stop together
// - configuration is refused while the emulator is tracing
// - both ends must run at the same baud rate
// - exactly one handshake scheme is active, hardware or flow control
// - hardware mode moves one character per handshake exchange on RTS/CTS/DSR/DTR
// - flow control mode stores received characters in a 96-byte buffer
// - flow mode sends XOFF at 50 percent full and XON at 35 percent
// - hardware mode drives CTS as the inverse of the receiver ready flag
`ifndef SCH_CFG_SVH
`define SCH_CFG_SVH

`define SCH_CLK_HZ 100000000
`define SCH_DIV_W 20

// register byte addresses
`define SCH_ADDR_CONFIG 12'h000
`define SCH_ADDR_STATUS 12'h004
`define SCH_ADDR_TXDATA 12'h008
`define SCH_ADDR_RXDATA 12'h00C

// config_command fields
`define SCH_CFG_MODE 0
`define SCH_CFG_BAUD_LO 1
`define SCH_CFG_BAUD_HI 3
`define SCH_CFG_LEN8 4
`define SCH_CFG_PAR_LO 5
`define SCH_CFG_PAR_HI 6
`define SCH_CFG_STOP2 7
`define SCH_CFG_W 8
`define SCH_CFG_RESET 8'h9A

// parity_operand codes
`define SCH_PAR_EVEN 2'h1
`define SCH_PAR_ODD 2'h2

// status fields
`define SCH_ST_RDY 0
`define SCH_ST_TXBUSY 1
`define SCH_ST_PAUSED 2
`define SCH_ST_OVERRUN 3
`define SCH_ST_RXERR 4
`define SCH_ST_XOFFSENT 5
`define SCH_ST_CNT_LO 8

// baud codes and rates
`define SCH_BAUD_300 3'h0
`define SCH_BAUD_600 3'h1
`define SCH_BAUD_1200 3'h2
`define SCH_BAUD_2400 3'h3
`define SCH_BAUD_4800 3'h4
`define SCH_BAUD_9600 3'h5
`define SCH_BAUD_19200 3'h6
`define SCH_RATE_300 300
`define SCH_RATE_600 600
`define SCH_RATE_1200 1200
`define SCH_RATE_2400 2400
`define SCH_RATE_4800 4800
`define SCH_RATE_9600 9600
`define SCH_RATE_19200 19200

// character framing
`define SCH_DATA_BITS 7
`define SCH_FRAME_W 12
`define SCH_BITCNT_W 4

// flow control
`define SCH_RX_DEPTH 96
`define SCH_XOFF_PCT 50
`define SCH_XON_PCT 35
`define SCH_XOFF_CHAR 8'h13
`define SCH_XON_CHAR 8'h11

`endif

// ===== logic/sch_channel.sv
// serial channel toward a PROM programmer, APB register access
// assumes trace_active comes from pclk logic; serial and handshake pins are asynchronous
`timescale 1ns/1ns
`include "sch_cfg.svh"
module sch_channel
   import sch_pkg::*;
#(
   parameter int DEPTH = `SCH_RX_DEPTH
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // emulator state
   input wire logic trace_active,
   // serial line and handshake
   input wire logic rxd,
   input wire logic rts,
   input wire logic dtr,
   output logic txd,
   output logic cts,
   output logic dsr
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);
   localparam logic [CW-1:0] XOFF_LVL = CW'((DEPTH * `SCH_XOFF_PCT + 99) / 100);
   localparam logic [CW-1:0] XON_LVL = CW'((DEPTH * `SCH_XON_PCT) / 100);

   // pin synchronisers
   logic [1:0] rxd_q, rts_q, dtr_q;
   logic rxd_s, rts_s, dtr_s;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_q <= 2'h3;
         rts_q <= 2'h0;
         dtr_q <= 2'h0;
      end else begin
         rxd_q <= {rxd_q[0], rxd};
         rts_q <= {rts_q[0], rts};
         dtr_q <= {dtr_q[0], dtr};
      end
   end
   assign rxd_s = rxd_q[1];
   assign rts_s = rts_q[1];
   assign dtr_s = dtr_q[1];

   // control state
   logic [`SCH_CFG_W-1:0] config_command, next_config_command;
   logic [7:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic tx_hold_valid, next_tx_hold_valid, paused, next_paused;
   logic [7:0] tx_hold, next_tx_hold;
   logic xoff_sent, next_xoff_sent, overrun, next_overrun, rx_err, next_rx_err;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_cts;
   logic flow_mode, len8, par_en, par_odd, stop2, push, pop, done, full;
   logic desired_off, flow_req, take_flow, take_hold;
   logic [1:0] parity_operand;
   logic [`SCH_DIV_W-1:0] div;
   logic rx_valid, rx_err_p;
   logic [7:0] rx_data;
   logic [31:0] status;

   // tx state
   sch_tx_state_t tx_state, next_tx_state;
   logic [`SCH_FRAME_W-1:0] shreg, next_shreg, frame;
   logic [`SCH_BITCNT_W-1:0] bits_left, next_bits_left, frame_len;
   logic [`SCH_DIV_W-1:0] bcnt, next_bcnt;
   logic next_txd;

   // one handshake scheme at a time
   assign flow_mode = config_command[`SCH_CFG_MODE];
   assign len8 = config_command[`SCH_CFG_LEN8];
   assign parity_operand = config_command[`SCH_CFG_PAR_HI:`SCH_CFG_PAR_LO];
   assign par_en = (parity_operand == `SCH_PAR_EVEN) || (parity_operand == `SCH_PAR_ODD);
   assign par_odd = parity_operand == `SCH_PAR_ODD;
   assign stop2 = config_command[`SCH_CFG_STOP2];

   // the far end must be set to the same rate; unlisted codes fall back to 9600
   always_comb begin
      case (config_command[`SCH_CFG_BAUD_HI:`SCH_CFG_BAUD_LO])
         `SCH_BAUD_300: div = `SCH_DIV_W'(`SCH_CLK_HZ / `SCH_RATE_300);
         `SCH_BAUD_600: div = `SCH_DIV_W'(`SCH_CLK_HZ / `SCH_RATE_600);
         `SCH_BAUD_1200: div = `SCH_DIV_W'(`SCH_CLK_HZ / `SCH_RATE_1200);
         `SCH_BAUD_2400: div = `SCH_DIV_W'(`SCH_CLK_HZ / `SCH_RATE_2400);
         `SCH_BAUD_4800: div = `SCH_DIV_W'(`SCH_CLK_HZ / `SCH_RATE_4800);
         `SCH_BAUD_19200: div = `SCH_DIV_W'(`SCH_CLK_HZ / `SCH_RATE_19200);
         default: div = `SCH_DIV_W'(`SCH_CLK_HZ / `SCH_RATE_9600);
      endcase
   end

   sch_rx u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .rxd(rxd_s),
      .div(div),
      .len8(len8),
      .par_en(par_en),
      .par_odd(par_odd),
      .valid(rx_valid),
      .data(rx_data),
      .err(rx_err_p)
   );

   assign status = {16'h0000, {(8 - CW){1'b0}}, count, 2'h0, xoff_sent, rx_err,
                    overrun, paused, tx_state == SCH_TX_SEND, count != '0};

   always_comb begin
      next_config_command = config_command;
      next_pready = psel && penable && !pready;
      next_prdata = prdata;
      next_pslverr = pslverr;
      next_tx_hold = tx_hold;
      next_tx_hold_valid = tx_hold_valid && !take_hold;
      next_overrun = overrun;
      next_rx_err = rx_err || rx_err_p;
      next_paused = paused;
      done = psel && penable && pready;
      pop = 1'b0;
      push = 1'b0;
      // in hardware mode there is only room for one character
      full = flow_mode ? (count == CW'(DEPTH)) : (count != '0);
      if (next_pready) begin
         next_prdata = 32'h0000_0000;
         next_pslverr = 1'b0;
         if (paddr == `SCH_ADDR_CONFIG) begin
            next_prdata = {24'h000000, config_command};
            next_pslverr = pwrite && trace_active;
         end else if (paddr == `SCH_ADDR_STATUS) begin
            next_prdata = status;
         end else if (paddr == `SCH_ADDR_TXDATA) begin
            next_pslverr = pwrite && tx_hold_valid;
         end else if (paddr == `SCH_ADDR_RXDATA) begin
            next_prdata = (count != '0) ? {24'h000000, mem[rd_ptr]} : 32'h0000_0000;
         end else begin
            next_pslverr = 1'b1;
         end
      end
      if (done && pwrite && !pslverr) begin
         if (paddr == `SCH_ADDR_CONFIG) begin
            // all five operands land in one write
            next_config_command = pwdata[`SCH_CFG_W-1:0];
         end else if (paddr == `SCH_ADDR_STATUS) begin
            next_overrun = overrun && !pwdata[`SCH_ST_OVERRUN];
            next_rx_err = (rx_err && !pwdata[`SCH_ST_RXERR]) || rx_err_p;
         end else if (paddr == `SCH_ADDR_TXDATA) begin
            next_tx_hold = pwdata[7:0];
            next_tx_hold_valid = 1'b1;
         end
      end
      if (done && !pwrite && paddr == `SCH_ADDR_RXDATA && count != '0) pop = 1'b1;
      if (rx_valid) begin
         // in flow mode xon/xoff steer our transmitter and are not stored
         if (flow_mode && rx_data == `SCH_XOFF_CHAR) begin
            next_paused = 1'b1;
         end else if (flow_mode && rx_data == `SCH_XON_CHAR) begin
            next_paused = 1'b0;
         end else if (full && !pop) begin
            next_overrun = 1'b1;
         end else begin
            push = 1'b1;
         end
      end
      if (!flow_mode) next_paused = 1'b0;
      next_count = count + CW'(push) - CW'(pop);
      next_wr_ptr = push ? ((wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1)) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1)) : rd_ptr;
      // hysteresis between the two fill levels
      if (count >= XOFF_LVL) desired_off = 1'b1;
      else if (count <= XON_LVL) desired_off = 1'b0;
      else desired_off = xoff_sent;
      flow_req = flow_mode && (desired_off != xoff_sent);
      next_xoff_sent = flow_mode && (take_flow ? desired_off : xoff_sent);
      // in hardware mode cts is the inverse of the receiver ready flag; flow mode holds it high
      next_cts = flow_mode ? 1'b1 : (next_count == '0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_command <= `SCH_CFG_RESET;
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         tx_hold <= 8'h00;
         tx_hold_valid <= 1'b0;
         overrun <= 1'b0;
         rx_err <= 1'b0;
         paused <= 1'b0;
         count <= '0;
         wr_ptr <= '0;
         rd_ptr <= '0;
         xoff_sent <= 1'b0;
         cts <= 1'b1;
         dsr <= 1'b0;
      end else begin
         config_command <= next_config_command;
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         tx_hold <= next_tx_hold;
         tx_hold_valid <= next_tx_hold_valid;
         overrun <= next_overrun;
         rx_err <= next_rx_err;
         paused <= next_paused;
         count <= next_count;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         xoff_sent <= next_xoff_sent;
         cts <= next_cts;
         dsr <= 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (push) mem[wr_ptr] <= rx_data;
   end

   // frame: start, 7 data bits, forced zero eighth bit, parity, stops
   function automatic logic [`SCH_BITCNT_W+`SCH_FRAME_W-1:0] build(input logic [7:0] d);
      logic [`SCH_FRAME_W-1:0] f;
      logic [`SCH_BITCNT_W-1:0] pos;
      f = '1;
      f[0] = 1'b0;
      f[`SCH_DATA_BITS:1] = d[`SCH_DATA_BITS-1:0];
      pos = `SCH_BITCNT_W'(`SCH_DATA_BITS + 1);
      if (len8) begin
         f[pos] = 1'b0;
         pos = pos + `SCH_BITCNT_W'(1);
      end
      if (par_en) begin
         f[pos] = (^d[`SCH_DATA_BITS-1:0]) ^ par_odd;
         pos = pos + `SCH_BITCNT_W'(1);
      end
      pos = pos + `SCH_BITCNT_W'(1) + `SCH_BITCNT_W'(stop2);
      return {pos, f};
   endfunction

   always_comb begin
      next_tx_state = tx_state;
      next_shreg = shreg;
      next_bits_left = bits_left;
      next_bcnt = bcnt + `SCH_DIV_W'(1);
      take_flow = 1'b0;
      take_hold = 1'b0;
      {frame_len, frame} = build(desired_off ? `SCH_XOFF_CHAR : `SCH_XON_CHAR);
      case (tx_state)
         SCH_TX_IDLE: begin
            next_bcnt = '0;
            if (flow_req) begin
               take_flow = 1'b1;
            end else if (tx_hold_valid && (flow_mode ? !paused : (rts_s && dtr_s))) begin
               // hardware mode waits for the peer's handshake lines
               // flow mode stops at a character boundary after xoff
               take_hold = 1'b1;
               {frame_len, frame} = build(tx_hold);
            end
            if (take_flow || take_hold) begin
               next_shreg = frame;
               next_bits_left = frame_len;
               next_tx_state = SCH_TX_SEND;
            end
         end
         SCH_TX_SEND: begin
            if (bcnt == div - `SCH_DIV_W'(1)) begin
               next_bcnt = '0;
               next_shreg = {1'b1, shreg[`SCH_FRAME_W-1:1]};
               next_bits_left = bits_left - `SCH_BITCNT_W'(1);
               if (bits_left == `SCH_BITCNT_W'(1)) next_tx_state = SCH_TX_IDLE;
            end
         end
         default: next_tx_state = SCH_TX_IDLE;
      endcase
      next_txd = next_shreg[0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= SCH_TX_IDLE;
         shreg <= '1;
         bits_left <= '0;
         bcnt <= '0;
         txd <= 1'b1;
      end else begin
         tx_state <= next_tx_state;
         shreg <= next_shreg;
         bits_left <= next_bits_left;
         bcnt <= next_bcnt;
         txd <= next_txd;
      end
   end
endmodule

// ===== logic/sch_pkg.sv
// types shared by the serial channel modules
// assumes nothing beyond the constants header
package sch_pkg;
   typedef enum logic [1:0] {SCH_RX_IDLE, SCH_RX_START, SCH_RX_DATA, SCH_RX_STOP} sch_rx_state_t;
   typedef enum logic {SCH_TX_IDLE, SCH_TX_SEND} sch_tx_state_t;
endpackage

// ===== logic/sch_rx.sv
// serial receiver: start detect, 7 to 9 data/parity bits, stop check
// assumes rxd is already synchronised to pclk and div is stable within a frame
`timescale 1ns/1ns
`include "sch_cfg.svh"
module sch_rx
   import sch_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // line and format
   input wire logic rxd,
   input wire logic [`SCH_DIV_W-1:0] div,
   input wire logic len8,
   input wire logic par_en,
   input wire logic par_odd,
   // result
   output logic valid,
   output logic [7:0] data,
   output logic err
);
   sch_rx_state_t state, next_state;
   logic [`SCH_DIV_W-1:0] bcnt, next_bcnt;
   logic [`SCH_BITCNT_W-1:0] idx, next_idx;
   logic [8:0] sh, next_sh;
   logic next_valid, next_err;
   logic [7:0] next_data;
   logic [`SCH_BITCNT_W-1:0] nbits, pidx;

   always_comb begin
      nbits = `SCH_BITCNT_W'(`SCH_DATA_BITS) + `SCH_BITCNT_W'(len8) + `SCH_BITCNT_W'(par_en);
      pidx = `SCH_BITCNT_W'(`SCH_DATA_BITS) + `SCH_BITCNT_W'(len8);
      next_state = state;
      next_bcnt = bcnt + `SCH_DIV_W'(1);
      next_idx = idx;
      next_sh = sh;
      next_valid = 1'b0;
      next_err = 1'b0;
      next_data = data;
      case (state)
         SCH_RX_IDLE: begin
            next_bcnt = '0;
            if (!rxd) next_state = SCH_RX_START;
         end
         SCH_RX_START: begin
            // sample mid start bit, reject glitches
            if (bcnt == (div >> 1)) begin
               next_bcnt = '0;
               next_idx = '0;
               next_state = rxd ? SCH_RX_IDLE : SCH_RX_DATA;
            end
         end
         SCH_RX_DATA: begin
            if (bcnt == div - `SCH_DIV_W'(1)) begin
               next_bcnt = '0;
               next_sh[idx] = rxd;
               next_idx = idx + `SCH_BITCNT_W'(1);
               if (idx == nbits - `SCH_BITCNT_W'(1)) next_state = SCH_RX_STOP;
            end
         end
         SCH_RX_STOP: begin
            if (bcnt == div - `SCH_DIV_W'(1)) begin
               next_state = SCH_RX_IDLE;
               next_valid = 1'b1;
               // eighth bit ignored and read as zero
               next_data = {1'b0, sh[`SCH_DATA_BITS-1:0]};
               // parity over the bits really received
               next_err = !rxd || (par_en && ((^sh[`SCH_DATA_BITS-1:0]) ^
                  (len8 && sh[`SCH_DATA_BITS]) ^ par_odd ^ sh[pidx]));
            end
         end
         default: next_state = SCH_RX_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SCH_RX_IDLE;
         bcnt <= '0;
         idx <= '0;
         sh <= '0;
         valid <= 1'b0;
         err <= 1'b0;
         data <= 8'h00;
      end else begin
         state <= next_state;
         bcnt <= next_bcnt;
         idx <= next_idx;
         sh <= next_sh;
         valid <= next_valid;
         err <= next_err;
         data <= next_data;
      end
   end
endmodule

// ===== testbench/sch_channel_properties.sv
// port assertions for the serial channel: bus timing, refusals, handshake lines
// assumes one pclk domain with asynchronous active-low presetn
`timescale 1ns/1ns
`include "sch_cfg.svh"
module sch_channel_properties #(
   parameter int DEPTH = 96
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // emulator state and serial side
   input wire logic trace_active,
   input wire logic txd,
   input wire logic cts,
   input wire logic dsr
);
   logic [3:0] since_acc, next_since_acc;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // cycles since the last bus answer; saturates so a long idle never wraps
   always_comb begin
      next_since_acc = since_acc;
      if (pready) next_since_acc = 4'h0;
      else if (since_acc != 4'hF) next_since_acc = since_acc + 4'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_acc <= 4'hF;
      else since_acc <= next_since_acc;
   end
   chk_ready_wait: assert property (psel && !penable |-> ##2 pready)
      else $error("pready not two edges after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_ready_cause: assert property (pready |-> psel && $past(penable))
      else $error("pready without access phase");
   chk_trace_refuse: assert property (psel && penable && !pready && pwrite &&
      paddr == `SCH_ADDR_CONFIG && trace_active |=> pready && pslverr)
      else $error("config write accepted while tracing");
   chk_bad_addr: assert property (psel && penable && !pready && paddr > 12'h00C
      |=> pready && pslverr)
      else $error("unmapped access not refused");
   chk_tx_reads0: assert property (pready && !pwrite &&
      paddr == `SCH_ADDR_TXDATA |-> prdata == 32'h0)
      else $error("transmit register read not zero");
   chk_dsr_on: assert property (presetn && $past(presetn) |-> dsr)
      else $error("dsr low after reset");
   chk_idle_reset: assert property ($rose(presetn) |-> txd && cts)
      else $error("serial side not idle at reset release");
   chk_cts_rise: assert property ($rose(cts) |-> since_acc <= 4'h4)
      else $error("cts rose without a bus access");
endmodule

bind sch_channel sch_channel_properties #(.DEPTH(DEPTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .trace_active(trace_active), .txd(txd), .cts(cts), .dsr(dsr)
);

// ===== testbench/sch_prog_model.sv
// serial peer standing in for the programmer: sends frames and captures them
// assumes the device runs at BIT pclk cycles per bit; line idles at mark
`timescale 1ns/1ns
module sch_prog_model #(
   parameter int BIT = 5208
) (
   // clock
   input wire logic pclk,
   // device side
   input wire logic txd,
   input wire logic cts,
   input wire logic dsr,
   output logic rxd,
   output logic rts,
   output logic dtr,
   // capture
   input wire logic [3:0] nbits,
   output logic [11:0] got,
   output int got_cnt
);
   initial begin
      rxd = 1'b1;
      rts = 1'b1;
      dtr = 1'b1;
      got = 12'h000;
      got_cnt = 0;
   end
   // peer handshake lines, high while the programmer is ready
   task automatic set_ready(input logic on);
      rts <= on;
      dtr <= on;
   endtask
   // start bit, then n bits lsb first; stop bits are part of bits
   // returns just after the middle of the last stop bit, where the device samples it
   task automatic send(input logic [11:0] bits, input int n);
      wait (cts === 1'b1 && dsr === 1'b1);
      @(posedge pclk);
      rxd <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(posedge pclk);
         rxd <= bits[i];
      end
      repeat (BIT / 2 + 32) @(posedge pclk);
      rxd <= 1'b1;
   endtask
   // samples mid-bit so a small rate error still lands inside each bit
   initial forever begin
      @(posedge pclk iff txd === 1'b0);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < nbits; i++) begin
         repeat (BIT) @(posedge pclk);
         got[i] = txd;
      end
      got_cnt++;
   end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the serial channel: registers, framing, handshakes
// assumes the programmer model on the serial pins and the bound checker
`timescale 1ns/1ns
`include "sch_cfg.svh"
module testbench;
   localparam int BIT = `SCH_CLK_HZ / `SCH_RATE_19200;
   typedef struct packed {
      logic w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] r;
      logic e;
   } sch_row_t;
   logic pclk, presetn, psel, penable, pwrite, trace_active, pready, pslverr, err;
   logic [11:0] paddr, got;
   logic [31:0] pwdata, prdata, rd;
   logic rxd, rts, dtr, txd, cts, dsr;
   logic [3:0] nbits;
   int got_cnt, miscompares, checked;
   sch_row_t rows [8];

   always #5 pclk = ~pclk;

   sch_channel DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trace_active(trace_active), .rxd(rxd), .rts(rts), .dtr(dtr), .txd(txd), .cts(cts),
      .dsr(dsr)
   );
   sch_prog_model #(.BIT(BIT)) u_prog (
      .pclk(pclk), .txd(txd), .cts(cts), .dsr(dsr), .rxd(rxd), .rts(rts), .dtr(dtr),
      .nbits(nbits), .got(got), .got_cnt(got_cnt)
   );

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic check(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, g, x);
      end
   endtask

   // txd must stay at mark for n edges
   task automatic expect_idle(input int n);
      logic quiet;
      quiet = 1'b1;
      repeat (n) begin
         @(posedge pclk);
         quiet &= txd;
      end
      check({31'h0, quiet}, 32'h1);
   endtask

   task automatic stop_test();
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // two received frames at 19200 take about 55k and 45k cycles; the rest is short
   initial begin
      repeat (105000) @(posedge pclk);
      miscompares++;
      stop_test();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      trace_active = 1'b0;
      nbits = 4'hA;
      rows = '{
         {1'b0, `SCH_ADDR_CONFIG, 32'h0, 32'h9A, 1'b0},
         {1'b0, `SCH_ADDR_STATUS, 32'h0, 32'h0, 1'b0},
         {1'b0, `SCH_ADDR_RXDATA, 32'h0, 32'h0, 1'b0},
         {1'b0, `SCH_ADDR_TXDATA, 32'h0, 32'h0, 1'b0},
         {1'b1, 12'h010, 32'h0, 32'h0, 1'b1},
         {1'b0, 12'h010, 32'h0, 32'h0, 1'b1},
         {1'b1, `SCH_ADDR_CONFIG, 32'h3C, 32'h0, 1'b0},
         {1'b0, `SCH_ADDR_CONFIG, 32'h0, 32'h3C, 1'b0}};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, rd, err);
         check({31'h0, err}, {31'h0, rows[i].e});
         if (!rows[i].w && !rows[i].e) check(rd, rows[i].r);
      end
      trace_active <= 1'b1;
      apb(1'b1, `SCH_ADDR_CONFIG, 32'h0, rd, err);
      check({31'h0, err}, 32'h1);
      trace_active <= 1'b0;
      apb(1'b0, `SCH_ADDR_CONFIG, 32'h0, rd, err);
      check(rd, 32'h3C);
      // 19200, 8 bits, even parity, 1 stop: both directions at once
      fork
         u_prog.send({2'b11, 8'hC1}, 10);
         apb(1'b1, `SCH_ADDR_TXDATA, 32'hD7, rd, err);
      join
      check({31'h0, cts}, 32'h0);
      apb(1'b0, `SCH_ADDR_RXDATA, 32'h0, rd, err);
      check(rd, 32'h41);
      repeat (4) @(posedge pclk);
      check({31'h0, cts}, 32'h1);
      for (int n = 0; n < 20000 && got_cnt == 0; n++) @(posedge pclk);
      check({20'h0, got}, 32'h357);
      // flow mode, 7 bits, no parity, 1 stop: a received pause code is not stored
      apb(1'b1, `SCH_ADDR_CONFIG, 32'h0D, rd, err);
      u_prog.send(12'h093, 8);
      repeat (4) @(posedge pclk);
      apb(1'b0, `SCH_ADDR_STATUS, 32'h0, rd, err);
      // paused, nothing stored, no overrun, and the earlier parity frame gave no error
      check(rd & 32'h7F1F, 32'h4);
      apb(1'b1, `SCH_ADDR_TXDATA, 32'h55, rd, err);
      expect_idle(100);
      // peer not ready: the held character must wait in hardware mode
      u_prog.set_ready(1'b0);
      apb(1'b1, `SCH_ADDR_CONFIG, 32'h3C, rd, err);
      expect_idle(100);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `SCH_ADDR_CONFIG, 32'h0, rd, err);
      check(rd, 32'h9A);
      stop_test();
   end
endmodule
